// >>> hdl/slt_pkg.sv
package slt_pkg;

  // ==========================================================
  // clock and timing
  localparam int CLK_HZ = 125_000_000;
  localparam int CLK_PER_MHZ = CLK_HZ / 1_000_000;
  // one lamp flash slot; sixteen slots make the two second period
  localparam int FLASH_SLOT_MS = 125;
  localparam int FLASH_CYC = CLK_HZ / 1000 * FLASH_SLOT_MS;
  localparam int SLOTS_PER_PERIOD = 16;
  // comm check inversion window
  localparam int COMM_MS = 500;
  localparam int COMM_CYC = CLK_HZ / 1000 * COMM_MS;
  // default trigger pulse width, rounded up to whole cycles
  localparam int TRIG_NS = 1000;
  localparam int TRIG_CYC = (TRIG_NS * CLK_PER_MHZ + 999) / 1000;

  // ==========================================================
  // register offsets (byte addresses)
  localparam logic [4:0] OFS_CTRL = 5'h00;
  localparam logic [4:0] OFS_TRIG = 5'h04;
  localparam logic [4:0] OFS_WIDTH = 5'h08;
  localparam logic [4:0] OFS_STATUS = 5'h0C;
  localparam logic [4:0] OFS_MASK = 5'h10;
  localparam logic [4:0] OFS_STATE = 5'h14;

  // ==========================================================
  // field positions
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_NONCRIT = 3;
  localparam int CTRL_CRIT = 4;
  localparam int CTRL_COMM = 5;
  localparam int TRIG_MODE_LSB = 0;
  localparam int TRIG_BEAM = 2;
  localparam int TRIG_POL = 3;
  localparam int TRIG_AUX = 4;
  localparam int ST_DET1 = 0;
  localparam int ST_DET2 = 1;
  localparam int ST_EOV1 = 2;
  localparam int ST_EOV2 = 3;
  localparam int ST_COMM = 4;
  localparam int ST_W = 5;
  localparam int STATE_GREEN = 16;
  localparam int STATE_RED = 17;
  localparam int STATE_YELLOW = 18;
  localparam int STATE_DET = 19;
  localparam int STATE_COMM = 20;
  localparam int STATE_MODE_LSB = 21;

  // ==========================================================
  // trigger modes and reset values
  localparam logic [1:0] TRIG_EOV = 2'h0;
  localparam logic [1:0] TRIG_DET = 2'h1;
  localparam logic [1:0] TRIG_PRES = 2'h2;
  localparam logic [1:0] RST_TRIG_MODE = TRIG_EOV;
  localparam logic RST_TRIG_BEAM = 1'h0;
  localparam logic RST_TRIG_POL = 1'h0;
  localparam logic RST_TRIG_AUX = 1'h1;
  localparam logic [15:0] RST_WIDTH = 16'(TRIG_CYC);
  localparam logic [ST_W-1:0] RST_MASK = 5'h00;

  // lamp sequencing modes, set by the firmware
  typedef enum logic [2:0] {
    LED_POWER_UP = 3'h0,
    LED_BOOT_BAD = 3'h1,
    LED_ST_RUN = 3'h2,
    LED_ST_FAIL = 3'h3,
    LED_INIT = 3'h4,
    LED_ROAD_CAL = 3'h5,
    LED_NORMAL = 3'h6
  } slt_led_mode_type;

endpackage

// >>> hdl/slt_pulse.sv
`timescale 1ns/1ps
module slt_pulse #(
  parameter int W = 16
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // request
  input wire logic fire,
  input wire logic [W-1:0] width,
  // pulse
  output logic active_q
);

  logic [W-1:0] cnt_q;

  if (W < 2) begin : g_bad_w
    $error("slt_pulse width counter too narrow");
  end

  // ==========================================================
  // width counter; a new fire restarts the pulse, width 0 acts as 1
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else if (fire) begin
      cnt_q <= (width == '0) ? W'(1) : width;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - W'(1);
    end
  end

  // high for exactly width cycles from the edge that takes fire
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      active_q <= 1'b0;
    end else begin
      active_q <= fire || (cnt_q > W'(1));
    end
  end

endmodule

// >>> hdl/slt_top.sv
`timescale 1ns/1ps
module slt_top import slt_pkg::*; #(
  parameter int FLASH_CYC_P = FLASH_CYC,
  parameter int COMM_CYC_P = COMM_CYC,
  parameter int PRES_W = 8
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // avalon-mm register slave
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // one-cycle events from scan processing
  input wire logic det_first,
  input wire logic det_second,
  input wire logic eov_first,
  input wire logic eov_second,
  // lamps
  output logic lamp_yellow,
  output logic lamp_green,
  output logic lamp_red,
  // trigger lines and message side
  output logic vehicle_detect_out,
  output logic aux_trigger_out,
  output logic edge_bytes_en,
  output logic msg_release,
  // interrupt
  output logic irq
);

  // ==========================================================
  // elaboration checks
  if (FLASH_CYC_P < 1 || COMM_CYC_P < 1) begin : g_bad_time
    $error("slt_top timing counts must be at least one cycle");
  end
  if (PRES_W < 1 || PRES_W > 16) begin : g_bad_pres
    $error("slt_top presence counter width out of range");
  end

  // ==========================================================
  // declarations
  slt_led_mode_type led_mode_q;
  logic noncrit_q;
  logic crit_q;
  logic [1:0] trig_mode_q;
  logic trig_beam_q;
  logic trig_pol_q;
  logic aux_en_q;
  logic [15:0] width_q;
  logic [ST_W-1:0] status_q;
  logic [ST_W-1:0] mask_q;
  logic [ST_W-1:0] ev_set;
  logic [31:0] flash_cnt_q;
  logic [3:0] slot_q;
  logic [31:0] comm_cnt_q;
  logic comm_act_q;
  logic comm_start;
  logic comm_end;
  logic [PRES_W-1:0] pres_q;
  logic pres_any;
  logic trig_fire;
  logic pulse_act;
  logic det_act;
  logic det_pin;
  logic [1:0] rel_q;
  logic green_d;
  logic red_d;
  logic app_mode;
  logic blink;
  logic wr_acc;
  logic [31:0] rd_d;

  // ==========================================================
  // bus slave: one wait cycle, then the access completes
  assign wr_acc = avs_write && !avs_waitrequest;

  // waitrequest idles high and drops for one cycle per request
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
    end else if ((avs_read || avs_write) && avs_waitrequest) begin
      avs_waitrequest <= 1'b0;
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  // read mux; unmapped addresses read as zero
  always_comb begin
    rd_d = 32'h0000_0000;
    unique case (avs_address)
      OFS_CTRL: begin
        rd_d[CTRL_MODE_LSB +: 3] = led_mode_q;
        rd_d[CTRL_NONCRIT] = noncrit_q;
        rd_d[CTRL_CRIT] = crit_q;
      end
      OFS_TRIG: begin
        rd_d[TRIG_MODE_LSB +: 2] = trig_mode_q;
        rd_d[TRIG_BEAM] = trig_beam_q;
        rd_d[TRIG_POL] = trig_pol_q;
        rd_d[TRIG_AUX] = aux_en_q;
      end
      OFS_WIDTH: rd_d[15:0] = width_q;
      OFS_STATUS: rd_d[ST_W-1:0] = status_q;
      OFS_MASK: rd_d[ST_W-1:0] = mask_q;
      OFS_STATE: begin
        rd_d[PRES_W-1:0] = pres_q;
        rd_d[STATE_GREEN] = lamp_green;
        rd_d[STATE_RED] = lamp_red;
        rd_d[STATE_YELLOW] = lamp_yellow;
        rd_d[STATE_DET] = vehicle_detect_out;
        rd_d[STATE_COMM] = comm_act_q;
        rd_d[STATE_MODE_LSB +: 3] = led_mode_q;
      end
      default: rd_d = 32'h0000_0000;
    endcase
  end

  // data is captured while waitrequest is high, so it stands when low
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && avs_waitrequest) begin
      avs_readdata <= rd_d;
    end
  end

  // ==========================================================
  // control registers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      led_mode_q <= LED_POWER_UP;
      noncrit_q <= 1'b0;
      crit_q <= 1'b0;
    end else if (wr_acc && avs_address == OFS_CTRL) begin
      led_mode_q <= slt_led_mode_type'(avs_writedata[CTRL_MODE_LSB +: 3]);
      noncrit_q <= avs_writedata[CTRL_NONCRIT];
      crit_q <= avs_writedata[CTRL_CRIT];
    end
  end

  // trigger setup; reset gives end-of-vehicle, first beam, active low
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      trig_mode_q <= RST_TRIG_MODE;
      trig_beam_q <= RST_TRIG_BEAM;
      trig_pol_q <= RST_TRIG_POL;
      aux_en_q <= RST_TRIG_AUX;
      width_q <= RST_WIDTH;
    end else if (wr_acc && avs_address == OFS_TRIG) begin
      trig_mode_q <= avs_writedata[TRIG_MODE_LSB +: 2];
      trig_beam_q <= avs_writedata[TRIG_BEAM];
      trig_pol_q <= avs_writedata[TRIG_POL];
      aux_en_q <= avs_writedata[TRIG_AUX];
    end else if (wr_acc && avs_address == OFS_WIDTH) begin
      width_q <= avs_writedata[15:0];
    end
  end

  // ==========================================================
  // interrupts: events are logged whatever the output mode
  assign ev_set = {comm_end, eov_second, eov_first, det_second,
                   det_first};

  // set wins over a write-one clear in the same cycle
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      status_q <= '0;
    end else if (wr_acc && avs_address == OFS_STATUS) begin
      status_q <= (status_q & ~avs_writedata[ST_W-1:0]) | ev_set;
    end else begin
      status_q <= status_q | ev_set;
    end
  end

  // mask register
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_q <= RST_MASK;
    end else if (wr_acc && avs_address == OFS_MASK) begin
      mask_q <= avs_writedata[ST_W-1:0];
    end
  end

  // level interrupt
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status_q & mask_q);
    end
  end

  // ==========================================================
  // flash timebase: sixteen slots make one two second period
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      flash_cnt_q <= 32'h0000_0000;
      slot_q <= 4'h0;
    end else if (flash_cnt_q == 32'(FLASH_CYC_P - 1)) begin
      flash_cnt_q <= 32'h0000_0000;
      slot_q <= slot_q + 4'h1;
    end else begin
      flash_cnt_q <= flash_cnt_q + 32'h0000_0001;
    end
  end

  // steady flash: half a second on, half a second off
  assign blink = slot_q[2];

  // ==========================================================
  // comm check window; a new command restarts it
  assign comm_start = wr_acc && avs_address == OFS_CTRL &&
                      avs_writedata[CTRL_COMM];
  assign comm_end = comm_act_q && comm_cnt_q == 32'h0000_0001 &&
                    !comm_start;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      comm_cnt_q <= 32'h0000_0000;
      comm_act_q <= 1'b0;
    end else if (comm_start) begin
      comm_cnt_q <= 32'(COMM_CYC_P);
      comm_act_q <= 1'b1;
    end else if (comm_cnt_q != 32'h0000_0000) begin
      comm_cnt_q <= comm_cnt_q - 32'h0000_0001;
      comm_act_q <= comm_cnt_q != 32'h0000_0001;
    end
  end

  // ==========================================================
  // vehicles in the second beam; saturates rather than wraps
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pres_q <= '0;
    end else if (det_second && !eov_second && pres_q != '1) begin
      pres_q <= pres_q + PRES_W'(1);
    end else if (eov_second && !det_second && pres_q != '0) begin
      pres_q <= pres_q - PRES_W'(1);
    end
  end

  assign pres_any = pres_q != '0;

  // ==========================================================
  // lamps
  assign app_mode = led_mode_q == LED_INIT ||
                    led_mode_q == LED_ROAD_CAL ||
                    led_mode_q == LED_NORMAL;

  // mode pattern first, then failure flashes override red only
  always_comb begin
    green_d = 1'b0;
    red_d = 1'b0;
    unique case (led_mode_q)
      LED_POWER_UP: begin
        green_d = 1'b0;
      end
      LED_BOOT_BAD: red_d = blink;
      LED_ST_RUN: green_d = blink;
      LED_ST_FAIL: red_d = blink;
      LED_INIT: begin
        green_d = blink;
        red_d = !blink;
      end
      LED_ROAD_CAL: green_d = 1'b1;
      LED_NORMAL: begin
        green_d = !pres_any;
        red_d = 1'b1;
      end
      default: begin
        green_d = 1'b0;
      end
    endcase
    if (app_mode && crit_q) begin
      red_d = slot_q < 4'h8 && !slot_q[0];
    end else if (app_mode && noncrit_q) begin
      red_d = slot_q == 4'h0;
    end
    if (app_mode && comm_act_q) begin
      green_d = !green_d;
    end
  end

  // lamp flops; yellow is the power lamp and stays on
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      lamp_yellow <= 1'b1;
      lamp_green <= 1'b0;
      lamp_red <= 1'b0;
    end else begin
      lamp_yellow <= 1'b1;
      lamp_green <= green_d;
      lamp_red <= red_d;
    end
  end

  // ==========================================================
  // trigger event selection
  always_comb begin
    trig_fire = 1'b0;
    unique case (trig_mode_q)
      TRIG_EOV: trig_fire = trig_beam_q ? eov_second : eov_first;
      TRIG_DET: trig_fire = trig_beam_q ? det_second : det_first;
      default: trig_fire = 1'b0;
    endcase
  end

  // pulse of programmable width, one per selected event
  slt_pulse #(
    .W(16)
  ) u_pulse (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .fire(trig_fire),
    .width(width_q),
    .active_q(pulse_act)
  );

  // presence level or pulse, flipped by a comm check
  assign det_act = ((trig_mode_q == TRIG_PRES) ? pres_any : pulse_act) ^
                   comm_act_q;
  assign det_pin = trig_pol_q ? det_act : !det_act;

  // both lines register the same level; aux disabled rests inactive
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      vehicle_detect_out <= !RST_TRIG_POL;
      aux_trigger_out <= !RST_TRIG_POL;
    end else begin
      vehicle_detect_out <= det_pin;
      aux_trigger_out <= aux_en_q ? det_pin : !trig_pol_q;
    end
  end

  // ==========================================================
  // message side: release lags the pin edge by one cycle
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rel_q <= 2'h0;
      msg_release <= 1'b0;
      edge_bytes_en <= 1'b0;
    end else begin
      rel_q <= {rel_q[0], |ev_set[ST_EOV2:ST_DET1]};
      msg_release <= rel_q[1];
      edge_bytes_en <= trig_mode_q == TRIG_DET;
    end
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  sequence no_fail_s;
    !crit_q && !noncrit_q && !comm_act_q;
  endsequence

  sequence pres_hold_s;
    trig_mode_q == TRIG_PRES && !trig_pol_q && pres_any && !comm_act_q;
  endsequence

  sequence pulse_req_s;
    trig_fire && trig_mode_q != TRIG_PRES && !trig_pol_q;
  endsequence

  boot_red_a:
  assert property (led_mode_q == LED_BOOT_BAD |=>
                   lamp_red == $past(blink) && !lamp_green)
    else $error("boot flash pattern wrong");

  noncrit_flash_a:
  assert property (app_mode && noncrit_q && !crit_q |=>
                   lamp_red == ($past(slot_q) == 4'h0))
    else $error("non-critical flash wrong");

  crit_burst_a:
  assert property (app_mode && crit_q |=>
                   lamp_red == ($past(slot_q) < 4'h8 && !$past(slot_q[0])))
    else $error("critical burst wrong");

  selftest_ok_a:
  assert property (led_mode_q == LED_ST_RUN |=>
                   !lamp_red && lamp_green == $past(blink))
    else $error("self-test lamps wrong");

  selftest_fail_a:
  assert property (led_mode_q == LED_ST_FAIL |=> !lamp_green)
    else $error("green lit after self-test failure");

  init_alt_a:
  assert property (led_mode_q == LED_INIT ##0 no_fail_s |=>
                   lamp_green != lamp_red)
    else $error("init lamps not alternating");

  road_cal_a:
  assert property (led_mode_q == LED_ROAD_CAL ##0 no_fail_s |=>
                   lamp_green && !lamp_red)
    else $error("road calibration lamps wrong");

  normal_green_a:
  assert property (led_mode_q == LED_NORMAL ##0 no_fail_s |=>
                   lamp_green == !$past(pres_any) && lamp_red)
    else $error("normal lamps wrong");

  comm_window_a:
  assert property (comm_start |=> comm_act_q &&
                   comm_cnt_q == 32'(COMM_CYC_P))
    else $error("comm check window not started");

  trig_pulse_a:
  assert property (pulse_req_s ##1 !comm_act_q |=> !vehicle_detect_out)
    else $error("trigger pulse missing");

  presence_a:
  assert property (pres_hold_s ##1 pres_hold_s |=> !vehicle_detect_out)
    else $error("presence level wrong");

  aux_copy_a:
  assert property ($past(aux_en_q) |->
                   aux_trigger_out == vehicle_detect_out)
    else $error("aux line differs from detect line");

  release_a:
  assert property ((eov_first || eov_second) |-> ##3 msg_release)
    else $error("message release late");

  edge_bytes_a:
  assert property (trig_mode_q == TRIG_DET |=> edge_bytes_en)
    else $error("edge bytes not requested");

endmodule

// >>> sim/slt_lane_ctrl.sv
`timescale 1ns/1ps
// ==========================================================
// roadside controller: samples the trigger line every clock
module slt_lane_ctrl (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // trigger line and the level it treats as active
  input wire logic line,
  input wire logic act_hi,
  // activations seen so far
  output logic [15:0] hits_q
);
  logic prev_q;
  // one count per inactive-to-active change; a held level counts once
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_q <= 1'b0;
      hits_q <= 16'h0000;
    end else begin
      prev_q <= (line == act_hi);
      if ((line == act_hi) && !prev_q) begin
        hits_q <= hits_q + 16'h0001;
      end
    end
  end
endmodule

// >>> sim/status_led_and_trigger_output_tb.sv
`timescale 1ns/1ps
module status_led_and_trigger_output_tb import slt_pkg::*; ;
  // ==========================================================
  // short counts keep lamp and comm windows to a few cycles
  localparam int FL = 4;
  localparam int CC = 20;
  logic ref_clk, rst_n, rd, wr, wq, yl, gr, rl, det, aux, ebe, mrel, irq;
  logic act_hi;
  logic [4:0] addr;
  logic [31:0] wdat, rdat, rword, rng;
  logic [3:0] ev;
  logic [15:0] hits, h0;
  int num_errors, n_compared;

  slt_top #(.FLASH_CYC_P(FL), .COMM_CYC_P(CC), .PRES_W(8)) u_dut (
    .ref_clk(ref_clk), .rst_n(rst_n),
    .avs_address(addr), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wdat), .avs_readdata(rdat), .avs_waitrequest(wq),
    .det_first(ev[0]), .det_second(ev[1]),
    .eov_first(ev[2]), .eov_second(ev[3]),
    .lamp_yellow(yl), .lamp_green(gr), .lamp_red(rl),
    .vehicle_detect_out(det), .aux_trigger_out(aux),
    .edge_bytes_en(ebe), .msg_release(mrel), .irq(irq));

  slt_lane_ctrl u_lane (.ref_clk(ref_clk), .rst_n(rst_n), .line(det),
    .act_hi(act_hi), .hits_q(hits));

  // free-running 125 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  // ==========================================================
  // helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  // which strobe should pulse the line for a mode and beam
  function automatic logic exp_pulse(input logic [1:0] m, input logic b,
                                     input int e);
    if (m == TRIG_EOV) return e == (b ? 3 : 2);
    if (m == TRIG_DET) return e == (b ? 1 : 0);
    return 1'b0;
  endfunction

  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic test_done;
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // one avalon access; waits for waitrequest low under a bound
  task automatic bus(input logic w, input logic [4:0] a,
                     input logic [31:0] d);
    int i;
    @(posedge ref_clk);
    addr <= a;
    wdat <= d;
    wr <= w;
    rd <= !w;
    for (i = 0; i < 20; i++) begin
      @(posedge ref_clk);
      if (!wq) break;
    end
    rword = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    if (i == 20) begin
      num_errors++;
      test_done;
    end
  endtask

  // one-cycle event strobe; returns at the edge that samples it
  task automatic fire(input int e);
    @(posedge ref_clk);
    ev[e] <= 1'b1;
    @(posedge ref_clk);
    ev <= 4'h0;
  endtask

  // lamp counts over one full 64-cycle flash period; -1 skips
  task automatic lamp(input logic [31:0] c, input int g, input int r,
                      input int x);
    int gc, rc, xc;
    gc = 0;
    rc = 0;
    xc = 0;
    bus(1'b1, OFS_CTRL, c);
    repeat (2) @(posedge ref_clk);
    repeat (64) begin
      @(posedge ref_clk);
      gc += int'(gr === 1'b1);
      rc += int'(rl === 1'b1);
      xc += int'((gr ^ rl) === 1'b1);
    end
    if (g >= 0) check("green lit", 32'(gc), 32'(g));
    if (r >= 0) check("red lit", 32'(rc), 32'(r));
    if (x >= 0) check("one lamp lit", 32'(xc), 32'(x));
    check("yellow", yl, 1'b1);
  endtask

  // ==========================================================
  // main sequence
  initial begin
    int n, k, first, cnt, rel;
    logic [1:0] m;
    logic [2:0] w;
    logic pol, pe;
    rst_n = 1'b0;
    rd = 1'b0;
    wr = 1'b0;
    addr = 5'h00;
    wdat = 32'h0000_0000;
    ev = 4'h0;
    act_hi = 1'b0;
    rng = 32'hF50D6678;
    num_errors = 0;
    n_compared = 0;
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    #1;
    check("reset line", {det, aux, ebe, irq}, 4'hC);
    bus(1'b0, OFS_TRIG, 32'h0);
    check("trig reset", rword, 32'h0000_0010);
    bus(1'b0, OFS_WIDTH, 32'h0);
    check("width reset", rword, 32'h0000_007D);
    bus(1'b0, 5'h18, 32'h0);
    check("unmapped", rword, 32'h0000_0000);
    // end-of-vehicle, detect and unused mode 3, each beam and strobe, random width and polarity
    for (int e = 0; e < 4; e++) begin
      for (int mi = 0; mi < 3; mi++) begin
        for (int b = 0; b < 2; b++) begin
          m = (mi == 2) ? 2'h3 : 2'(mi);
          rng = xs(rng);
          w = rng[2:0];
          pol = rng[3];
          pe = exp_pulse(m, 1'(b), e);
          bus(1'b1, OFS_WIDTH, 32'(w) + 32'h1);
          bus(1'b1, OFS_TRIG, {27'h1, pol, 1'(b), m});
          act_hi <= pol;
          repeat (2) @(posedge ref_clk);
          check("idle level", det, !pol);
          h0 = hits;
          first = 0;
          cnt = 0;
          rel = 0;
          fire(e);
          for (k = 1; k <= 14; k++) begin
            @(posedge ref_clk);
            #1;
            if (det === pol) cnt++;
            if (det === pol && first == 0) first = k;
            if (mrel === 1'b1) rel = k;
            check("aux copy", aux, det);
          end
          check("pulse len", 32'(cnt), pe ? 32'(w) + 32'h1 : 32'h0);
          if (pe) check("pulse start", 32'(first), 32'h1);
          if (pe) check("msg release", 32'(rel), 32'h2);
          check("edge bytes", ebe, m == TRIG_DET);
          check("lane hits", 32'(hits - h0), 32'(pe));
          bus(1'b0, OFS_STATUS, 32'h0);
          check("event status", rword[e], 1'b1);
          bus(1'b1, OFS_STATUS, 32'h1F);
        end
      end
    end
    // interrupt raised, masked and cleared
    bus(1'b1, OFS_MASK, 32'h01);
    fire(1);
    repeat (4) @(posedge ref_clk);
    check("masked irq", irq, 1'b0);
    fire(0);
    repeat (4) @(posedge ref_clk);
    check("irq set", irq, 1'b1);
    bus(1'b1, OFS_STATUS, 32'h1F);
    repeat (3) @(posedge ref_clk);
    check("irq clear", irq, 1'b0);
    // mid-run reset must bring the setup back to its reset values
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    #1;
    check("reset again", {det, aux, ebe, irq}, 4'hC);
    bus(1'b0, OFS_MASK, 32'h0);
    check("mask reset", rword, 32'h0000_0000);
    bus(1'b0, OFS_TRIG, 32'h0);
    check("trig reset again", rword, 32'h0000_0010);
    // presence holds while any vehicle remains in the second beam
    bus(1'b1, OFS_TRIG, 32'h12);
    rng = xs(rng);
    n = 2 + int'(rng[1:0]);
    repeat (n) fire(1);
    repeat (n - 1) fire(3);
    repeat (3) @(posedge ref_clk);
    check("presence held", {det, aux}, 2'h0);
    bus(1'b0, OFS_STATE, 32'h0);
    check("presence count", rword[7:0], 8'h01);
    fire(3);
    repeat (3) @(posedge ref_clk);
    check("presence gone", det, 1'b1);
    // lamp sequencing per mode and failure flag
    lamp(32'h0, 0, 0, -1);
    lamp(32'h1, 0, 32, -1);
    lamp(32'h2, 32, 0, -1);
    lamp(32'h3, 0, 32, -1);
    lamp(32'h4, -1, -1, 64);
    lamp(32'h5, 64, 0, -1);
    lamp(32'h6, 64, 64, -1);
    lamp(32'hE, 64, 4, -1);
    lamp(32'h16, -1, 16, -1);
    // comm check inverts green and the line together for the window
    bus(1'b1, OFS_TRIG, 32'h10);
    bus(1'b1, OFS_CTRL, 32'h26);
    repeat (3) @(posedge ref_clk);
    check("comm inverted", {gr, det}, 2'h0);
    repeat (CC + 2) @(posedge ref_clk);
    check("comm restored", {gr, det}, 2'h3);
    bus(1'b0, OFS_STATUS, 32'h0);
    check("comm done", rword[ST_COMM], 1'b1);
    test_done;
  end
endmodule
